// *** scsi_cmd_validator.sv ***
// Target-side command checker: command blocks arrive over Wishbone, results read back.
// Assumes media engine on this clock; spindle ready pin is synchronised here.
//
// Decided for this implementation: the Wishbone register port and the register offsets.
`timescale 1ns/1ps

module scsi_cmd_validator (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Wishbone slave
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Media engine
    output logic mediaReq,
    output scsi_cmd_pkg::media_op_t mediaOp,
    output logic [31:0] mediaLba,
    output logic [16:0] mediaCount,
    input wire logic mediaDone,
    input wire logic [15:0] mediaBadCount,
    // Spindle
    output logic spinUp,
    input wire logic spinReadyPin
);
    cdb_fields_if fields ();

    logic rstMeta;
    logic rstN;
    logic readyMeta;
    logic readySync;
    logic [7:0] cdbReg [0:9];
    logic [31:0] lastLbaReg;
    logic [7:0] paramReg;
    logic goPulse;
    scsi_cmd_pkg::state_t stateReg;
    scsi_cmd_pkg::state_t stateNext;
    logic stoppedReg;
    logic doneReg;
    logic [7:0] statusReg;
    logic [7:0] keyReg;
    logic [7:0] ascReg;
    logic [15:0] infoReg;
    logic [31:0] xferLbaReg;
    logic [16:0] xferCntReg;
    logic waitSpin;
    logic unitReady;
    logic busWrite;
    logic busRead;
    logic [31:0] readData;

    // Reset released through two flops so every flop leaves reset together
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    // Spindle ready comes from the motor controller, another timing domain
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            readyMeta <= 1'b0;
            readySync <= 1'b0;
        end else begin
            readyMeta <= spinReadyPin;
            readySync <= readyMeta;
        end
    end

    assign unitReady = readySync && !stoppedReg;

    // Decoder hookup
    assign fields.cdb = cdbReg;
    assign fields.lastLba = lastLbaReg;
    assign fields.diagSub = paramReg;

    cdb_decoder decoder (
        .f(fields.dec)
    );

    // Wishbone: one wait state, ack dropped in the cycle after it is given
    assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign busRead = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    // Command block bytes, byte lanes honoured
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            for (int i = 0; i < 10; i++) begin
                cdbReg[i] <= 8'h00;
            end
        end else if (busWrite && stateReg == scsi_cmd_pkg::S_IDLE) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    if (wb_adr_i == scsi_cmd_pkg::CDB_LO_OFS) begin
                        cdbReg[b] <= wb_dat_i[8*b +: 8];
                    end else if (wb_adr_i == scsi_cmd_pkg::CDB_MID_OFS) begin
                        cdbReg[b + 4] <= wb_dat_i[8*b +: 8];
                    end else if (wb_adr_i == scsi_cmd_pkg::CDB_HI_OFS && b < 2) begin
                        cdbReg[b + 8] <= wb_dat_i[8*b +: 8];
                    end
                end
            end
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            lastLbaReg <= scsi_cmd_pkg::LAST_LBA_RST;
            paramReg <= scsi_cmd_pkg::PARAM_RST;
        end else if (busWrite) begin
            if (wb_adr_i == scsi_cmd_pkg::LAST_LBA_OFS) begin
                for (int b = 0; b < 4; b++) begin
                    if (wb_sel_i[b]) begin
                        lastLbaReg[8*b +: 8] <= wb_dat_i[8*b +: 8];
                    end
                end
            end else if (wb_adr_i == scsi_cmd_pkg::PARAM_OFS && wb_sel_i[0]) begin
                paramReg <= wb_dat_i[7:0];
            end
        end
    end

    // Go is ignored while a command is in flight
    assign goPulse = busWrite && wb_adr_i == scsi_cmd_pkg::CTRL_OFS && wb_sel_i[0]
        && wb_dat_i[scsi_cmd_pkg::CTRL_GO_BIT] && stateReg == scsi_cmd_pkg::S_IDLE;

    // Command sequencer
    always_comb begin
        stateNext = stateReg;
        case (stateReg)
            scsi_cmd_pkg::S_IDLE: begin
                if (goPulse) begin
                    stateNext = scsi_cmd_pkg::S_CHECK;
                end
            end
            scsi_cmd_pkg::S_CHECK: begin
                // Pending flags only settle at the CHECK edge
                stateNext = scsi_cmd_pkg::S_WAIT;
            end
            scsi_cmd_pkg::S_WAIT: begin
                if (mediaReq && mediaDone) begin
                    stateNext = scsi_cmd_pkg::S_FINISH;
                end else if (!mediaReq && (!waitSpin || readySync == spinUp)) begin
                    stateNext = scsi_cmd_pkg::S_FINISH;
                end
            end
            scsi_cmd_pkg::S_FINISH: begin
                stateNext = scsi_cmd_pkg::S_IDLE;
            end
            default: begin
                stateNext = scsi_cmd_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            stateReg <= scsi_cmd_pkg::S_IDLE;
        end else begin
            stateReg <= stateNext;
        end
    end

    // Spindle state and stopped flag
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            spinUp <= 1'b1;
            stoppedReg <= 1'b0;
            waitSpin <= 1'b0;
        end else if (goPulse) begin
            waitSpin <= 1'b0;
        end else if (stateReg == scsi_cmd_pkg::S_CHECK && fields.kind == scsi_cmd_pkg::KIND_SPIN) begin
            spinUp <= fields.startBit;
            stoppedReg <= !fields.startBit;
            waitSpin <= !fields.immed;
        end
    end

    // Media request held until the engine reports done
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            mediaReq <= 1'b0;
            mediaOp <= scsi_cmd_pkg::MEDIA_DIAG;
            mediaLba <= 32'h0000_0000;
            mediaCount <= 17'h00000;
        end else if (stateReg == scsi_cmd_pkg::S_CHECK && !fields.reject) begin
            mediaLba <= fields.lba;
            mediaCount <= fields.count;
            if (fields.kind == scsi_cmd_pkg::KIND_DIAG && fields.runTest) begin
                mediaReq <= 1'b1;
                mediaOp <= scsi_cmd_pkg::MEDIA_DIAG;
            end else if (fields.kind == scsi_cmd_pkg::KIND_VERIFY && fields.count != 17'h00000 && unitReady) begin
                mediaReq <= 1'b1;
                mediaOp <= scsi_cmd_pkg::MEDIA_VERIFY;
            end else if (fields.kind == scsi_cmd_pkg::KIND_WRITE && unitReady) begin
                mediaReq <= 1'b1;
                mediaOp <= scsi_cmd_pkg::MEDIA_WRITE;
            end
        end else if (stateReg == scsi_cmd_pkg::S_WAIT && mediaDone) begin
            mediaReq <= 1'b0;
        end
    end

    // Completion status and sense data
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            statusReg <= scsi_cmd_pkg::ST_GOOD;
            keyReg <= scsi_cmd_pkg::KEY_NONE;
            ascReg <= scsi_cmd_pkg::ASC_NONE;
            infoReg <= 16'h0000;
            xferLbaReg <= 32'h0000_0000;
            xferCntReg <= 17'h00000;
        end else if (goPulse) begin
            statusReg <= scsi_cmd_pkg::ST_GOOD;
            keyReg <= scsi_cmd_pkg::KEY_NONE;
            ascReg <= scsi_cmd_pkg::ASC_NONE;
            infoReg <= 16'h0000;
        end else if (stateReg == scsi_cmd_pkg::S_CHECK) begin
            xferLbaReg <= fields.lba;
            xferCntReg <= fields.count;
            if (fields.reject) begin
                statusReg <= scsi_cmd_pkg::ST_CHECK;
                keyReg <= fields.rejectKey;
                ascReg <= fields.rejectAsc;
            end else if (!unitReady && (fields.kind == scsi_cmd_pkg::KIND_READY
                    || fields.kind == scsi_cmd_pkg::KIND_VERIFY || fields.kind == scsi_cmd_pkg::KIND_WRITE)) begin
                statusReg <= scsi_cmd_pkg::ST_CHECK;
                keyReg <= scsi_cmd_pkg::KEY_NOT_READY;
                ascReg <= scsi_cmd_pkg::ASC_NOT_READY;
            end
        end else if (stateReg == scsi_cmd_pkg::S_WAIT && mediaReq && mediaDone && mediaBadCount != 16'h0000) begin
            statusReg <= scsi_cmd_pkg::ST_CHECK;
            keyReg <= scsi_cmd_pkg::KEY_MEDIUM;
            ascReg <= scsi_cmd_pkg::ASC_UNCORRECTABLE;
            infoReg <= mediaBadCount;
        end
    end

    // Done flag: set on finish wins over the clear by a new go
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            doneReg <= 1'b0;
        end else if (stateReg == scsi_cmd_pkg::S_FINISH) begin
            doneReg <= 1'b1;
        end else if (goPulse) begin
            doneReg <= 1'b0;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        readData = 32'h0000_0000;
        if (wb_adr_i == scsi_cmd_pkg::CDB_LO_OFS) begin
            readData = {cdbReg[3], cdbReg[2], cdbReg[1], cdbReg[0]};
        end else if (wb_adr_i == scsi_cmd_pkg::CDB_MID_OFS) begin
            readData = {cdbReg[7], cdbReg[6], cdbReg[5], cdbReg[4]};
        end else if (wb_adr_i == scsi_cmd_pkg::CDB_HI_OFS) begin
            readData = {16'h0000, cdbReg[9], cdbReg[8]};
        end else if (wb_adr_i == scsi_cmd_pkg::STATUS_OFS) begin
            readData[scsi_cmd_pkg::STAT_BUSY_BIT] = stateReg != scsi_cmd_pkg::S_IDLE;
            readData[scsi_cmd_pkg::STAT_DONE_BIT] = doneReg;
            readData[scsi_cmd_pkg::STAT_STOPPED_BIT] = stoppedReg;
            readData[scsi_cmd_pkg::STAT_LEN_LSB +: 4] = fields.cdbLen;
            readData[scsi_cmd_pkg::STAT_CODE_LSB +: 8] = statusReg;
            readData[scsi_cmd_pkg::STAT_KEY_LSB +: 8] = keyReg;
            readData[scsi_cmd_pkg::STAT_ASC_LSB +: 8] = ascReg;
        end else if (wb_adr_i == scsi_cmd_pkg::INFO_OFS) begin
            readData = {16'h0000, infoReg};
        end else if (wb_adr_i == scsi_cmd_pkg::LAST_LBA_OFS) begin
            readData = lastLbaReg;
        end else if (wb_adr_i == scsi_cmd_pkg::PARAM_OFS) begin
            readData = {24'h000000, paramReg};
        end else if (wb_adr_i == scsi_cmd_pkg::XFER_LBA_OFS) begin
            readData = xferLbaReg;
        end else if (wb_adr_i == scsi_cmd_pkg::XFER_CNT_OFS) begin
            readData = {15'h0000, xferCntReg};
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (busRead) begin
            wb_dat_o <= readData;
        end
    end
endmodule

// *** scsi_cmd_pkg.sv ***
// Shared constants for the command block checker.
// Assumes a 32-bit classic Wishbone register bus and a 50 MHz core clock.
package scsi_cmd_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CDB_LO_OFS = 8'h04;
    localparam logic [7:0] CDB_MID_OFS = 8'h08;
    localparam logic [7:0] CDB_HI_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] INFO_OFS = 8'h14;
    localparam logic [7:0] LAST_LBA_OFS = 8'h18;
    localparam logic [7:0] PARAM_OFS = 8'h1C;
    localparam logic [7:0] XFER_LBA_OFS = 8'h20;
    localparam logic [7:0] XFER_CNT_OFS = 8'h24;

    // Reset values
    localparam logic [31:0] LAST_LBA_RST = 32'h0000_FFFF;
    localparam logic [7:0] PARAM_RST = 8'h00;

    // Control and status bit positions
    localparam int CTRL_GO_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_STOPPED_BIT = 2;
    localparam int STAT_LEN_LSB = 4;
    localparam int STAT_CODE_LSB = 8;
    localparam int STAT_KEY_LSB = 16;
    localparam int STAT_ASC_LSB = 24;

    // Command block field positions
    localparam int UNIT_OFFLINE_BIT = 0;
    localparam int DEVICE_OFFLINE_BIT = 1;
    localparam int SELFTEST_BIT = 2;
    localparam int IMMED_BIT = 0;
    localparam int START_BIT = 0;
    localparam int BYTE_COMPARE_BIT = 1;
    localparam int SHORT_LBA_MSB = 4;

    // Opcodes
    localparam logic [7:0] OP_TEST_READY = 8'h00;
    localparam logic [7:0] OP_SHORT_WRITE = 8'h0A;
    localparam logic [7:0] OP_SPIN = 8'h1B;
    localparam logic [7:0] OP_SELFTEST = 8'h1D;
    localparam logic [7:0] OP_VERIFY = 8'h2F;
    localparam logic [2:0] GROUP_SHORT = 3'h0;
    localparam logic [2:0] GROUP_LONG = 3'h1;
    localparam logic [3:0] LEN_SHORT = 4'h6;
    localparam logic [3:0] LEN_LONG = 4'hA;
    localparam logic [16:0] SHORT_ZERO_COUNT = 17'h00100;

    // Status bytes, sense keys and codes
    localparam logic [7:0] ST_GOOD = 8'h00;
    localparam logic [7:0] ST_CHECK = 8'h02;
    localparam logic [7:0] KEY_NONE = 8'h00;
    localparam logic [7:0] KEY_NOT_READY = 8'h02;
    localparam logic [7:0] KEY_MEDIUM = 8'h03;
    localparam logic [7:0] KEY_ILLEGAL = 8'h05;
    localparam logic [7:0] ASC_NONE = 8'h00;
    localparam logic [7:0] ASC_NOT_READY = 8'h04;
    localparam logic [7:0] ASC_UNCORRECTABLE = 8'h11;
    localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
    localparam logic [7:0] ASC_BAD_BLOCK = 8'h21;
    localparam logic [7:0] ASC_BAD_CDB_FIELD = 8'h24;
    localparam logic [7:0] ASC_BAD_PARAM = 8'h26;

    // Legal diagnostic subcommand in the parameter list
    localparam logic [7:0] DIAG_SUB_LEGAL = 8'h00;

    typedef enum logic [2:0] {
        KIND_NONE = 3'h0,
        KIND_READY = 3'h1,
        KIND_WRITE = 3'h2,
        KIND_SPIN = 3'h3,
        KIND_DIAG = 3'h4,
        KIND_VERIFY = 3'h5
    } cmd_kind_t;

    typedef enum logic [1:0] {
        MEDIA_DIAG = 2'h0,
        MEDIA_VERIFY = 2'h1,
        MEDIA_WRITE = 2'h2
    } media_op_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_CHECK = 2'b01,
        S_WAIT = 2'b11,
        S_FINISH = 2'b10
    } state_t;

endpackage

// *** cdb_fields_if.sv ***
// Carries the captured command block and its decoded fields.
// Assumes the decoder is purely combinational on the same clock.
`timescale 1ns/1ps
interface cdb_fields_if;
    logic [7:0] cdb [0:9];
    logic [31:0] lastLba;
    logic [7:0] diagSub;
    scsi_cmd_pkg::cmd_kind_t kind;
    logic [3:0] cdbLen;
    logic [31:0] lba;
    logic [16:0] count;
    logic immed;
    logic startBit;
    logic runTest;
    logic reject;
    logic [7:0] rejectKey;
    logic [7:0] rejectAsc;

    modport dec (input cdb, lastLba, diagSub,
        output kind, cdbLen, lba, count, immed, startBit, runTest, reject, rejectKey, rejectAsc);
    modport use_side (output cdb, lastLba, diagSub,
        input kind, cdbLen, lba, count, immed, startBit, runTest, reject, rejectKey, rejectAsc);
endinterface

// *** cdb_decoder.sv ***
// Field decode and illegal-field checks of one command block.
// Assumes the block bytes stay stable while the result is read.
`timescale 1ns/1ps
module cdb_decoder (
    // Block and results
    cdb_fields_if.dec f
);
    logic [2:0] group;
    logic [15:0] paramLen;
    logic [32:0] endLba;
    logic [7:0] flagByte;

    always_comb begin
        group = f.cdb[0][7:5];
        flagByte = f.cdb[1];
        paramLen = {f.cdb[3], f.cdb[4]};
        f.kind = scsi_cmd_pkg::KIND_NONE;
        f.cdbLen = scsi_cmd_pkg::LEN_SHORT;
        f.lba = 32'h0000_0000;
        f.count = 17'h00000;
        f.immed = flagByte[scsi_cmd_pkg::IMMED_BIT];
        f.startBit = f.cdb[4][scsi_cmd_pkg::START_BIT];
        f.runTest = 1'b0;
        f.reject = 1'b0;
        f.rejectKey = scsi_cmd_pkg::KEY_NONE;
        f.rejectAsc = scsi_cmd_pkg::ASC_NONE;
        if (group == scsi_cmd_pkg::GROUP_LONG) begin
            f.cdbLen = scsi_cmd_pkg::LEN_LONG;
        end
        case (f.cdb[0])
            scsi_cmd_pkg::OP_TEST_READY: begin
                f.kind = scsi_cmd_pkg::KIND_READY;
            end
            scsi_cmd_pkg::OP_SHORT_WRITE: begin
                f.kind = scsi_cmd_pkg::KIND_WRITE;
                f.lba = {11'h000, flagByte[scsi_cmd_pkg::SHORT_LBA_MSB:0], f.cdb[2], f.cdb[3]};
                f.count = (f.cdb[4] == 8'h00) ? scsi_cmd_pkg::SHORT_ZERO_COUNT : {9'h000, f.cdb[4]};
            end
            scsi_cmd_pkg::OP_SPIN: begin
                f.kind = scsi_cmd_pkg::KIND_SPIN;
            end
            scsi_cmd_pkg::OP_SELFTEST: begin
                f.kind = scsi_cmd_pkg::KIND_DIAG;
                f.runTest = flagByte[scsi_cmd_pkg::SELFTEST_BIT];
                // First offence wins
                if (flagByte[scsi_cmd_pkg::DEVICE_OFFLINE_BIT]) begin
                    f.reject = 1'b1;
                    f.rejectAsc = scsi_cmd_pkg::ASC_BAD_CDB_FIELD;
                end else if (!flagByte[scsi_cmd_pkg::SELFTEST_BIT] && flagByte[scsi_cmd_pkg::UNIT_OFFLINE_BIT]) begin
                    f.reject = 1'b1;
                    f.rejectAsc = scsi_cmd_pkg::ASC_BAD_CDB_FIELD;
                end else if (flagByte[scsi_cmd_pkg::SELFTEST_BIT] && paramLen != 16'h0000) begin
                    f.reject = 1'b1;
                    f.rejectAsc = scsi_cmd_pkg::ASC_BAD_CDB_FIELD;
                end else if (!flagByte[scsi_cmd_pkg::SELFTEST_BIT] && paramLen != 16'h0000
                        && f.diagSub != scsi_cmd_pkg::DIAG_SUB_LEGAL) begin
                    f.reject = 1'b1;
                    f.rejectAsc = scsi_cmd_pkg::ASC_BAD_PARAM;
                end
            end
            scsi_cmd_pkg::OP_VERIFY: begin
                f.kind = scsi_cmd_pkg::KIND_VERIFY;
                f.lba = {f.cdb[2], f.cdb[3], f.cdb[4], f.cdb[5]};
                f.count = {1'b0, f.cdb[7], f.cdb[8]};
            end
            default: begin
                f.reject = 1'b1;
                f.rejectAsc = scsi_cmd_pkg::ASC_BAD_OPCODE;
            end
        endcase
        // Range check shared by verify and short write
        endLba = {1'b0, f.lba} + {16'h0000, f.count} - 33'h0_0000_0001;
        if (f.kind == scsi_cmd_pkg::KIND_VERIFY || f.kind == scsi_cmd_pkg::KIND_WRITE) begin
            if (f.lba > f.lastLba) begin
                f.reject = 1'b1;
                f.rejectAsc = scsi_cmd_pkg::ASC_BAD_BLOCK;
            end else if (f.count != 17'h00000 && endLba > {1'b0, f.lastLba}) begin
                f.reject = 1'b1;
                f.rejectAsc = scsi_cmd_pkg::ASC_BAD_BLOCK;
            end
        end
        if (f.reject) begin
            f.rejectKey = scsi_cmd_pkg::KEY_ILLEGAL;
        end
    end
endmodule

// *** scsi_cmd_validator_props.sv ***
// Port checker for the command block checker.
// Assumes one clock domain; bound onto the top module.
`timescale 1ns/1ps
module scsi_cmd_validator_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Wishbone
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Media and spindle
    input wire logic mediaReq,
    input wire scsi_cmd_pkg::media_op_t mediaOp,
    input wire logic [31:0] mediaLba,
    input wire logic [16:0] mediaCount,
    input wire logic mediaDone,
    input wire logic spinUp
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic go;
    // Seen at take and ack edges
    assign go = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h00 && wb_dat_i[0];
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_hole;
        s_req ##0 (!wb_we_i && wb_adr_i == 8'h30);
    endsequence
    property p_ack_time; s_req |=> wb_ack_o; endproperty
    a_ack_time: assert property (p_ack_time) else $error("ack late");
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack too long");
    property p_hole; s_hole |=> wb_dat_o == 32'h0; endproperty
    a_hole: assert property (p_hole) else $error("unmapped read nonzero");
    property p_launch; $rose(mediaReq) |-> $past(go, 1) || $past(go, 2); endproperty
    a_launch: assert property (p_launch) else $error("media request without go");
    property p_hold; mediaReq && !mediaDone && !$past(mediaDone) |=> mediaReq; endproperty
    a_hold: assert property (p_hold) else $error("media request dropped");
    property p_drop; mediaReq && mediaDone |-> ##[1:2] !mediaReq; endproperty
    a_drop: assert property (p_drop) else $error("media request stuck");
    property p_write;
        $rose(mediaReq) && mediaOp == scsi_cmd_pkg::MEDIA_WRITE |->
            mediaCount inside {[17'h1:17'h100]} && mediaLba[31:21] == 11'h0;
    endproperty
    a_write: assert property (p_write) else $error("short write fields");
    property p_verify;
        $rose(mediaReq) && mediaOp == scsi_cmd_pkg::MEDIA_VERIFY |-> mediaCount != 17'h0 && !mediaCount[16];
    endproperty
    a_verify: assert property (p_verify) else $error("verify count");
    property p_spin; $changed(spinUp) |-> $past(go, 1) || $past(go, 2); endproperty
    a_spin: assert property (p_spin) else $error("spindle moved alone");
endmodule
bind scsi_cmd_validator scsi_cmd_validator_props u_props (.core_clk, .reset_n, .wb_adr_i, .wb_dat_i,
    .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .mediaReq, .mediaOp, .mediaLba,
    .mediaCount, .mediaDone, .spinUp);

// *** media_spindle_model.sv ***
// Media engine and spindle on the far side.
// Assumes the core clock; bad sector count set by the bench.
`timescale 1ns/1ps
module media_spindle_model (
    // Clock
    input wire logic core_clk,
    // Media engine
    input wire logic mediaReq,
    input wire logic [15:0] badCfg,
    output logic mediaDone = 1'b0,
    output logic [15:0] mediaBadCount = 16'h0000,
    // Spindle
    input wire logic spinUp,
    output logic spinReadyPin = 1'b1
);
    logic served = 1'b0;
    int waitN = 2;
    int spinN = 0;
    always @(posedge core_clk) begin
        mediaDone <= 1'b0;
        // Count is garbage outside the done cycle
        mediaBadCount <= ~mediaBadCount;
        if (!mediaReq) begin
            served <= 1'b0;
            waitN <= 1 + $urandom % 6;
        end else if (!served && waitN == 0) begin
            mediaDone <= 1'b1;
            mediaBadCount <= badCfg;
            served <= 1'b1;
        end else if (!served) begin
            waitN <= waitN - 1;
        end
        // Slow spindle, so immediate status is seen early
        spinN <= (spinReadyPin == spinUp) ? 0 : spinN + 1;
        if (spinN == 40) begin
            spinReadyPin <= spinUp;
        end
    end
endmodule

// *** scsi_cmd_validator_tb_top.sv ***
// Bench: Wishbone host sending command blocks, notes checked on read acks.
// Assumes the register map and one-cycle ack of the design.
`timescale 1ns/1ps
module scsi_cmd_validator_tb_top;
    typedef struct {logic [31:0] e; logic [31:0] m;} note_t;
    note_t notes[$];
    note_t nt;
    logic core_clk = 0, reset_n = 0, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, d, lba, mediaLba;
    logic [3:0] wb_sel_i = 4'hF;
    logic wb_ack_o, mediaReq, mediaDone, spinUp, spinReadyPin;
    logic [15:0] bad = 16'h0000, mediaBadCount, cnt;
    logic [16:0] mediaCount;
    scsi_cmd_pkg::media_op_t mediaOp;
    int fail_count = 0, check_count = 0, n;
    always #10 core_clk = ~core_clk;
    scsi_cmd_validator u_dut (.core_clk, .reset_n, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
        .wb_stb_i, .wb_dat_o, .wb_ack_o, .mediaReq, .mediaOp, .mediaLba, .mediaCount, .mediaDone,
        .mediaBadCount, .spinUp, .spinReadyPin);
    media_spindle_model u_far (.core_clk, .mediaReq, .badCfg(bad), .mediaDone, .mediaBadCount, .spinUp,
        .spinReadyPin);
    task tally_and_finish;
        $display("checks %0d fails %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task fail(input string s);
        fail_count++;
        $display("[FAIL] %0t %0s", $time, s);
    endtask
    task chk(input logic c);
        check_count++;
        if (c !== 1'b1) fail("pin state");
    endtask
    // One classic cycle; zero mask: no check
    task bus(input logic w, input logic [7:0] a, input logic [31:0] v, m, e);
        @(posedge core_clk);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= v;
        if (!w) notes.push_back('{e, m});
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        d = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        if (wb_ack_o !== 1'b1) begin
            fail("no ack");
            tally_and_finish;
        end
    endtask
    always @(posedge core_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && notes.size() > 0) begin
            nt = notes.pop_front();
            if (nt.m != 0) begin
                check_count++;
                if (((wb_dat_o ^ nt.e) & nt.m) !== 32'h0) fail("read data");
            end
        end
    end
    function automatic logic [79:0] vcdb(input logic [31:0] l, input logic [15:0] c);
        vcdb = {8'h00, c[7:0], c[15:8], 8'h00, l[7:0], l[15:8], l[23:16], l[31:24], 8'h00, 8'h2F};
    endfunction
    // Expected status from key, code, group
    task run(input logic [79:0] c, input logic [7:0] k, a);
        bus(1, 8'h04, c[31:0], 0, 0);
        bus(1, 8'h08, c[63:32], 0, 0);
        bus(1, 8'h0C, {16'h0000, c[79:64]}, 0, 0);
        bus(1, 8'h00, 32'h1, 0, 0);
        d = 32'h0;
        for (int i = 0; i < 200 && d[1] !== 1'b1; i++) bus(0, 8'h10, 0, 0, 0);
        if (d[1] !== 1'b1) begin
            fail("no done");
            tally_and_finish;
        end
        bus(0, 8'h10, 0, 32'hFFFF_FFF3, {a, k, (k != 0) ? 8'h02 : 8'h00, (c[7:5] != 0) ? 4'hA : 4'h6, 4'h2});
    endtask
    initial begin
        void'($urandom(26069));
        repeat (8) @(posedge core_clk);
        reset_n <= 1;
        repeat (3) @(posedge core_clk);
        bus(0, 8'h18, 0, 32'hFFFF_FFFF, 32'h0000_FFFF);
        bus(1, 8'h18, 32'h00FF_FFFF, 0, 0);
        bus(0, 8'h18, 0, 32'hFFFF_FFFF, 32'h00FF_FFFF);
        bus(0, 8'h30, 0, 32'hFFFF_FFFF, 0);
        $display("registers done");
        run(80'h0, 8'h00, 8'h00);
        run(80'h041D, 8'h00, 8'h00);
        run(80'h021D, 8'h05, 8'h24);
        run(80'h011D, 8'h05, 8'h24);
        run(80'h01_0000_041D, 8'h05, 8'h24);
        bus(1, 8'h1C, 32'h5A, 0, 0);
        run(80'h01_0000_001D, 8'h05, 8'h26);
        bus(1, 8'h1C, 32'h0, 0, 0);
        bad <= 16'h0003;
        run(80'h041D, 8'h03, 8'h11);
        bus(0, 8'h14, 0, 32'h0000_FFFF, 32'h3);
        bad <= 16'h0000;
        $display("self-test done");
        run(vcdb(32'h00FF_FFF0, 16'h0010), 8'h00, 8'h00);
        run(vcdb(32'h00FF_FFF0, 16'h0011), 8'h05, 8'h21);
        run(vcdb(32'h0100_0000, 16'h0000), 8'h05, 8'h21);
        run(vcdb(32'h0000_0010, 16'h0000), 8'h00, 8'h00);
        repeat (4) begin
            lba = $urandom % 32'h00FF_0000;
            cnt = 16'(1 + $urandom % 256);
            run(vcdb(lba, cnt), 8'h00, 8'h00);
            bus(0, 8'h20, 0, 32'hFFFF_FFFF, lba);
            bus(0, 8'h24, 0, 32'h0001_FFFF, {16'h0000, cnt});
        end
        $display("verify done");
        run(80'hCDAB_1F0A, 8'h00, 8'h00);
        bus(0, 8'h20, 0, 32'hFFFF_FFFF, 32'h001F_ABCD);
        bus(0, 8'h24, 0, 32'h0001_FFFF, 32'h0000_0100);
        run(80'h3F, 8'h05, 8'h20);
        $display("write done");
        run(80'h011B, 8'h00, 8'h00);
        chk(spinUp === 1'b0 && spinReadyPin === 1'b1);
        run(80'h0, 8'h02, 8'h04);
        run(vcdb(32'h10, 16'h1), 8'h02, 8'h04);
        repeat (60) @(posedge core_clk);
        run(80'h01_0000_001B, 8'h00, 8'h00);
        chk(spinUp === 1'b1 && spinReadyPin === 1'b1);
        run(80'h0, 8'h00, 8'h00);
        $display("spin done");
        tally_and_finish;
    end
endmodule
